// ---- hw/homing_pkg.sv ----
// Shared constants and types for the homing sequencer, methods 5 to 10.
// Assumes a single 250 MHz clock domain; no registers reach software.
package homing_pkg;

  // Speed command codes
  localparam logic [1:0] SPD_STOP = 2'h0;
  localparam logic [1:0] SPD_LOW  = 2'h1;
  localparam logic [1:0] SPD_HIGH = 2'h2;

  // What a step waits for
  localparam logic [1:0] EDGE_RISE  = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;
  localparam logic [1:0] EDGE_INDEX = 2'h2;
  localparam logic [1:0] EDGE_END   = 2'h3;

  localparam logic FAST = 1'h1;
  localparam logic SLOW = 1'h0;
  localparam logic FWD  = 1'h1;
  localparam logic REV  = 1'h0;

  // Method numbers
  localparam logic [3:0] M5  = 4'h5;
  localparam logic [3:0] M6  = 4'h6;
  localparam logic [3:0] M7  = 4'h7;
  localparam logic [3:0] M8  = 4'h8;
  localparam logic [3:0] M9  = 4'h9;
  localparam logic [3:0] M10 = 4'ha;

  // Step index at start, and reset values
  localparam logic [1:0] STEP_FIRST = 2'h0;
  localparam logic [1:0] STEP_SKIP  = 2'h1;
  localparam logic [3:0] METHOD_RST = 4'h0;
  localparam logic [2:0] SYNC_RST   = 3'h0;

  typedef struct packed {
    logic [1:0] kind;
    logic       fast;
    logic       fwd;
  } step_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_DECEL} state_t;

endpackage : homing_pkg

// ---- hw/homing_seq.sv ----
// Homing sequencer for one servo axis, methods 5 to 10.
// Assumes switch, limit, index and zero-speed pins are asynchronous;
// start and method come from logic on clk_sys.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - M5 switch off: fast reverse to rise, stop
// - M5 then slow forward to fall, index forward
// - M6 off: fast rev rise, fwd fall, rev rise
// - M6 on: skip fast phase, index reverse
// - M7 off: fast fwd rise, slow rev fall
// - M7 on: slow reverse fall, index reverse
// - M7 limit: fast rev fall, fwd rise, rev fall
// - M8 off: fast fwd rise, rev fall, fwd rise
// - M8 on: slow rev fall, fwd rise, index
// - M8 limit: fast rev fall, fwd rise, index
// - M9 off: fast fwd fall, rev rise, index
// - M9 on: same order as switch off
// - M9 limit: fast rev rise, fwd fall, rev rise
// - M10 off: fast fwd fall, rev rise, fwd fall
// - M10 on: same order as switch off
// - M10 limit: fast rev rise, fwd fall, index fwd
// - Start samples switch, picks branch
module homing_seq (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Command
  input  wire logic       start,
  input  wire logic [3:0] method,
  // Pins
  input  wire logic       home_sw,
  input  wire logic       lim_fwd,
  input  wire logic       lim_rev,
  input  wire logic       index_pulse,
  input  wire logic       zero_speed,
  // Motion and status
  output logic [1:0]      speed_cmd,
  output logic            dir_fwd,
  output logic            busy,
  output logic            done,
  output logic            fault
);
  import homing_pkg::*;

  function automatic step_t step_of(input logic [3:0] m, input logic lb,
                                    input logic [1:0] i);
    step_t s;
    s = '{EDGE_END, SLOW, REV};
    if (!lb) begin
      case (m)
        M5: case (i)
          2'h0: s = '{EDGE_RISE, FAST, REV};
          2'h1: s = '{EDGE_FALL, SLOW, FWD};
          2'h2: s = '{EDGE_INDEX, SLOW, FWD};
          default: ;
        endcase
        M6: case (i)
          2'h0: s = '{EDGE_RISE, FAST, REV};
          2'h1: s = '{EDGE_FALL, SLOW, FWD};
          2'h2: s = '{EDGE_RISE, SLOW, REV};
          2'h3: s = '{EDGE_INDEX, SLOW, REV};
          default: ;
        endcase
        M7: case (i)
          2'h0: s = '{EDGE_RISE, FAST, FWD};
          2'h1: s = '{EDGE_FALL, SLOW, REV};
          2'h2: s = '{EDGE_INDEX, SLOW, REV};
          default: ;
        endcase
        M8: case (i)
          2'h0: s = '{EDGE_RISE, FAST, FWD};
          2'h1: s = '{EDGE_FALL, SLOW, REV};
          2'h2: s = '{EDGE_RISE, SLOW, FWD};
          2'h3: s = '{EDGE_INDEX, SLOW, FWD};
          default: ;
        endcase
        M9: case (i)
          2'h0: s = '{EDGE_FALL, FAST, FWD};
          2'h1: s = '{EDGE_RISE, SLOW, REV};
          2'h2: s = '{EDGE_INDEX, SLOW, REV};
          default: ;
        endcase
        M10: case (i)
          2'h0: s = '{EDGE_FALL, FAST, FWD};
          2'h1: s = '{EDGE_RISE, SLOW, REV};
          2'h2: s = '{EDGE_FALL, SLOW, FWD};
          2'h3: s = '{EDGE_INDEX, SLOW, FWD};
          default: ;
        endcase
        default: ;
      endcase
    end else begin
      case (m)
        M7: case (i)
          2'h0: s = '{EDGE_FALL, FAST, REV};
          2'h1: s = '{EDGE_RISE, SLOW, FWD};
          2'h2: s = '{EDGE_FALL, SLOW, REV};
          2'h3: s = '{EDGE_INDEX, SLOW, REV};
          default: ;
        endcase
        M8: case (i)
          2'h0: s = '{EDGE_FALL, FAST, REV};
          2'h1: s = '{EDGE_RISE, SLOW, FWD};
          2'h2: s = '{EDGE_INDEX, SLOW, FWD};
          default: ;
        endcase
        M9: case (i)
          2'h0: s = '{EDGE_RISE, FAST, REV};
          2'h1: s = '{EDGE_FALL, SLOW, FWD};
          2'h2: s = '{EDGE_RISE, SLOW, REV};
          2'h3: s = '{EDGE_INDEX, SLOW, REV};
          default: ;
        endcase
        M10: case (i)
          2'h0: s = '{EDGE_RISE, FAST, REV};
          2'h1: s = '{EDGE_FALL, SLOW, FWD};
          2'h2: s = '{EDGE_INDEX, SLOW, FWD};
          default: ;
        endcase
        default: ;
      endcase
    end
    return s;
  endfunction : step_of

  // Pin synchronisers, third stage for edges
  logic [2:0] home_sr;
  logic [2:0] index_sr;
  logic [1:0] fl_sr;
  logic [1:0] rl_sr;
  logic [1:0] zs_sr;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      home_sr  <= SYNC_RST;
      index_sr <= SYNC_RST;
      fl_sr    <= SYNC_RST[1:0];
      rl_sr    <= SYNC_RST[1:0];
      zs_sr    <= SYNC_RST[1:0];
    end else begin
      home_sr  <= {home_sr[1:0], home_sw};
      index_sr <= {index_sr[1:0], index_pulse};
      fl_sr    <= {fl_sr[0], lim_fwd};
      rl_sr    <= {rl_sr[0], lim_rev};
      zs_sr    <= {zs_sr[0], zero_speed};
    end
  end

  logic home_s;
  logic home_rise;
  logic home_fall;
  logic index_rise;
  logic lim_fwd_s;
  logic lim_rev_s;
  logic zero_s;

  assign home_s     = home_sr[1];
  assign home_rise  = home_sr[1] && !home_sr[2];
  assign home_fall  = !home_sr[1] && home_sr[2];
  assign index_rise = index_sr[1] && !index_sr[2];
  assign lim_fwd_s  = fl_sr[1];
  assign lim_rev_s  = rl_sr[1];
  assign zero_s     = zs_sr[1];

  // Sequencer state
  state_t     state;
  state_t     next_state;
  logic [3:0] method_q;
  logic [3:0] next_method;
  logic       lim_br;
  logic       next_lim_br;
  logic [1:0] step_idx;
  logic [1:0] next_step_idx;
  logic [1:0] next_speed;
  logic       next_dir;
  logic       next_busy;
  logic       next_done;
  logic       next_fault;
  step_t      cur;
  step_t      nxt;
  logic       hit;
  logic       lim_turn;
  logic       lim_stop;
  logic       valid_m;

  always_comb begin
    cur = step_of(method_q, lim_br, step_idx);
    valid_m = (method >= M5) && (method <= M10);
    case (cur.kind)
      EDGE_RISE:  hit = home_rise;
      EDGE_FALL:  hit = home_fall;
      EDGE_INDEX: hit = index_rise;
      default:    hit = 1'h0;
    endcase
    lim_turn = lim_fwd_s && cur.fwd && cur.fast && !lim_br && (method_q >= M7);
    lim_stop = cur.fwd ? lim_fwd_s : lim_rev_s;
    next_state    = state;
    next_method   = method_q;
    next_lim_br   = lim_br;
    next_step_idx = step_idx;
    next_done     = done;
    next_fault    = fault;
    case (state)
      ST_IDLE: begin
        if (start && valid_m) begin
          next_state    = ST_SEEK;
          next_method   = method;
          next_lim_br   = 1'h0;
          next_done     = 1'h0;
          next_fault    = 1'h0;
          next_step_idx = (home_s && method <= M8) ? STEP_SKIP : STEP_FIRST;
        end else if (start) begin
          next_fault = 1'h1;
          next_done  = 1'h0;
        end
      end
      ST_SEEK: begin
        if (lim_turn) begin
          next_lim_br   = 1'h1;
          next_step_idx = STEP_FIRST;
        end else if (lim_stop) begin
          next_state = ST_IDLE;
          next_fault = 1'h1;
        end else if (hit && cur.kind == EDGE_INDEX) begin
          next_state = ST_IDLE;
          next_done  = 1'h1;
        end else if (hit && cur.fast) begin
          next_state = ST_DECEL;
        end else if (hit) begin
          next_step_idx = step_idx + 2'h1;
        end
      end
      ST_DECEL: begin
        if (zero_s) begin
          next_state    = ST_SEEK;
          next_step_idx = step_idx + 2'h1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    nxt        = step_of(next_method, next_lim_br, next_step_idx);
    next_busy  = next_state != ST_IDLE;
    next_dir   = nxt.fwd;
    next_speed = SPD_STOP;
    if (next_state == ST_SEEK) begin
      next_speed = nxt.fast ? SPD_HIGH : SPD_LOW;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      method_q  <= METHOD_RST;
      lim_br    <= 1'h0;
      step_idx  <= STEP_FIRST;
      speed_cmd <= SPD_STOP;
      dir_fwd   <= REV;
      busy      <= 1'h0;
      done      <= 1'h0;
      fault     <= 1'h0;
    end else begin
      state     <= next_state;
      method_q  <= next_method;
      lim_br    <= next_lim_br;
      step_idx  <= next_step_idx;
      speed_cmd <= next_speed;
      dir_fwd   <= next_dir;
      busy      <= next_busy;
      done      <= next_done;
      fault     <= next_fault;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence start_with(logic [3:0] m, logic sw);
    state == ST_IDLE && start && method == m && home_s == sw;
  endsequence

  sequence fast_hit;
    state == ST_SEEK && cur.fast && hit && !lim_turn && !lim_stop;
  endsequence

  sequence index_hit;
    state == ST_SEEK && cur.kind == EDGE_INDEX && hit && !lim_stop;
  endsequence

  m5_off_start_a: assert property (start_with(M5, 1'h0) |=>
    speed_cmd == SPD_HIGH && !dir_fwd) else $error("m5 off start wrong");
  m5_on_start_a: assert property (start_with(M5, 1'h1) |=>
    speed_cmd == SPD_LOW && dir_fwd) else $error("m5 on start wrong");
  m6_on_start_a: assert property (start_with(M6, 1'h1) |=>
    speed_cmd == SPD_LOW && dir_fwd) else $error("m6 on start wrong");
  m7_on_start_a: assert property (start_with(M7, 1'h1) |=>
    speed_cmd == SPD_LOW && !dir_fwd) else $error("m7 on start wrong");
  m8_on_start_a: assert property (start_with(M8, 1'h1) |=>
    speed_cmd == SPD_LOW && !dir_fwd) else $error("m8 on start wrong");
  m9_on_start_a: assert property (start_with(M9, 1'h1) |=>
    speed_cmd == SPD_HIGH && dir_fwd) else $error("m9 on start wrong");
  m10_on_start_a: assert property (start_with(M10, 1'h1) |=>
    speed_cmd == SPD_HIGH && dir_fwd) else $error("m10 on start wrong");
  branch_sample_a: assert property (state == ST_IDLE && start && valid_m |=>
    step_idx == (($past(home_s) && method_q <= M8) ? STEP_SKIP : STEP_FIRST))
    else $error("start branch wrong");
  decel_stop_a: assert property (fast_hit |=>
    state == ST_DECEL && speed_cmd == SPD_STOP ##1 speed_cmd == SPD_STOP)
    else $error("no stop after fast edge");
  limit_turn_a: assert property (state == ST_SEEK && lim_turn |=>
    lim_br && speed_cmd == SPD_HIGH && !dir_fwd) else $error("limit turn wrong");
  index_done_a: assert property (index_hit |=>
    done && !busy && speed_cmd == SPD_STOP) else $error("index not final");
  done_hold_a: assert property (done && !start |=> done && speed_cmd == SPD_STOP)
    else $error("done dropped");

endmodule : homing_seq
`default_nettype wire

// ---- sim/axis_model.sv ----
// Axis model: position, home switch, forward and reverse limits, index and decel.
// Assumes the speed codes of homing_pkg and the sequencer's clock.
`timescale 1ns/1ns
`default_nettype none
module axis_model
  import homing_pkg::*;
(
  // Clock and setup
  input  wire logic       clk_sys,
  input  wire logic       load,
  input  wire logic [7:0] load_pos,
  input  wire logic [3:0] decel_cyc,
  // Commands
  input  wire logic [1:0] speed_cmd,
  input  wire logic       dir_fwd,
  // Pins
  output logic            home_sw,
  output logic            lim_fwd,
  output logic            lim_rev,
  output logic            index_pulse,
  output logic            zero_speed
);
  logic [7:0] pos      = 8'h50;
  logic [3:0] tick     = 4'h0;
  logic [3:0] stop_cnt = 4'h0;

  // One step per 2 cycles fast, per 8 slow
  always @(posedge clk_sys) begin
    if (load) begin
      pos <= load_pos;
    end else if (speed_cmd != SPD_STOP) begin
      stop_cnt <= 4'h0;
      tick <= tick + 4'h1;
      if (tick >= ((speed_cmd == SPD_HIGH) ? 4'h1 : 4'h7)) begin
        tick <= 4'h0;
        pos <= dir_fwd ? pos + 8'h1 : pos - 8'h1;
      end
    end else if (stop_cnt != decel_cyc) begin
      stop_cnt <= stop_cnt + 4'h1;
    end
  end

  // Switch over 40..60, limit from 100, index every 16
  assign home_sw     = (pos >= 8'h28) && (pos <= 8'h3c);
  assign lim_fwd     = pos >= 8'h64;
  assign lim_rev     = pos == 8'h00;
  assign index_pulse = pos[3:0] == 4'h0;
  assign zero_speed  = (speed_cmd == SPD_STOP) && (stop_cnt == decel_cyc);
endmodule : axis_model
`default_nettype wire

// ---- sim/homing_seq_tb.sv ----
// Testbench for the homing sequencer, methods 5 to 10.
// Assumes axis_model on the pins; moves are traced as nibble codes.
`timescale 1ns/1ns
`default_nettype none
module homing_seq_tb;
  import homing_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        nrst      = 1'b0;
  logic        start     = 1'b0;
  logic [3:0]  method    = 4'h0;
  logic        load      = 1'b0;
  logic [7:0]  load_pos  = 8'h0;
  logic [3:0]  decel_cyc = 4'h0;
  logic        home_sw, lim_fwd, lim_rev, index_pulse, zero_speed;
  logic [1:0]  speed_cmd;
  logic        dir_fwd, busy, done, fault;
  logic [31:0] trace     = 32'h0;
  logic        trace_clr = 1'b0;
  logic [3:0]  last      = 4'h0;
  logic [3:0]  code;
  int          fails     = 0;
  int          compares  = 0;
  int          cycles    = 0;

  always #2 clk_sys = ~clk_sys;

  homing_seq DUT (.clk_sys(clk_sys), .nrst(nrst), .start(start), .method(method),
    .home_sw(home_sw), .lim_fwd(lim_fwd), .lim_rev(lim_rev), .index_pulse(index_pulse),
    .zero_speed(zero_speed), .speed_cmd(speed_cmd), .dir_fwd(dir_fwd), .busy(busy),
    .done(done), .fault(fault));

  axis_model AXIS (.clk_sys(clk_sys), .load(load), .load_pos(load_pos),
    .decel_cyc(decel_cyc), .speed_cmd(speed_cmd), .dir_fwd(dir_fwd), .home_sw(home_sw),
    .lim_fwd(lim_fwd), .lim_rev(lim_rev), .index_pulse(index_pulse),
    .zero_speed(zero_speed));

  // Move code: 0 stop, 4/5 fast rev/fwd, 2/3 slow rev/fwd
  assign code = (speed_cmd == SPD_STOP) ? 4'h0 : {1'b0, speed_cmd, dir_fwd};

  always @(negedge clk_sys) begin
    if (trace_clr) begin
      trace <= 32'h0;
    end else if (code !== last) begin
      trace <= {trace[27:0], code};
      last <= code;
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic pulse(input logic [3:0] m);
    start <= 1'b1;
    method <= m;
    @(negedge clk_sys);
    start <= 1'b0;
  endtask : pulse

  task automatic go(input logic [3:0] m, input logic [7:0] p);
    @(negedge clk_sys);
    load <= 1'b1;
    load_pos <= p;
    @(negedge clk_sys);
    load <= 1'b0;
    repeat (4) @(negedge clk_sys);
    trace_clr <= 1'b1;
    @(negedge clk_sys);
    trace_clr <= 1'b0;
    pulse(m);
    @(negedge clk_sys);
  endtask : go

  task automatic finish_run(input logic [31:0] exp, input logic [1:0] df);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    // Let the last stop code land in the trace
    @(negedge clk_sys);
    check(trace, exp);
    check({30'h0, done, fault}, {30'h0, df});
  endtask : finish_run

  task automatic run(input logic [3:0] m, input logic [7:0] p, input logic [31:0] exp);
    go(m, p);
    check({31'h0, busy}, 32'h1);
    finish_run(exp, 2'h2);
  endtask : run

  task automatic test_m5();
    decel_cyc <= 4'h0;
    run(M5, 8'h50, 32'h4030);
    run(M5, 8'h32, 32'h30);
    $display("m5 end");
  endtask : test_m5

  task automatic test_m6();
    decel_cyc <= 4'hf;
    run(M6, 8'h50, 32'h40320);
    run(M6, 8'h32, 32'h320);
    $display("m6 end");
  endtask : test_m6

  task automatic test_m7();
    run(M7, 8'h14, 32'h5020);
    run(M7, 8'h32, 32'h20);
    run(M7, 8'h46, 32'h540320);
    $display("m7 end");
  endtask : test_m7

  task automatic test_m8();
    decel_cyc <= 4'h3;
    run(M8, 8'h14, 32'h50230);
    run(M8, 8'h32, 32'h230);
    run(M8, 8'h46, 32'h54030);
    $display("m8 end");
  endtask : test_m8

  task automatic test_m9();
    run(M9, 8'h14, 32'h5020);
    run(M9, 8'h32, 32'h5020);
    run(M9, 8'h46, 32'h540320);
    $display("m9 end");
  endtask : test_m9

  task automatic test_m10();
    run(M10, 8'h14, 32'h50230);
    run(M10, 8'h32, 32'h50230);
    run(M10, 8'h46, 32'h54030);
    $display("m10 end");
  endtask : test_m10

  task automatic test_lim();
    go(M5, 8'h14);
    finish_run(32'h40, 2'h1);
    $display("limit stop end");
  endtask : test_lim

  task automatic test_bad();
    go(4'h3, 8'h32);
    check({29'h0, busy, done, fault}, 32'h1);
    $display("bad method end");
  endtask : test_bad

  task automatic test_busy();
    go(M5, 8'h50);
    repeat (20) @(negedge clk_sys);
    pulse(4'h3);
    finish_run(32'h4030, 2'h2);
    $display("start while busy end");
  endtask : test_busy

  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (16) @(negedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    check({27'h0, speed_cmd, dir_fwd, busy, done, fault}, 32'h0);
    test_m5();
    test_m6();
    test_m7();
    test_m8();
    test_m9();
    test_m10();
    test_lim();
    test_bad();
    test_busy();
    finish_test();
  end
endmodule : homing_seq_tb
`default_nettype wire
